//--- src/tda_params.svh
`ifndef TDA_PARAMS_SVH
`define TDA_PARAMS_SVH
// Display row
`define TDA_PIX_COUNT   711
`define TDA_PIX_LAST    10'h2C6
// Register byte offsets
`define TDA_ADR_CTRL    8'h00
`define TDA_ADR_CFG     8'h04
`define TDA_ADR_AVG     8'h08
`define TDA_ADR_STAT    8'h0C
`define TDA_ADR_RDADR   8'h10
`define TDA_ADR_RDDAT   8'h14
// Control register bit positions
`define TDA_CB_EN2      0
`define TDA_CB_SINGLE   1
`define TDA_CB_PARAM    2
`define TDA_CB_STORE    3
`define TDA_CB_SAVE     4
`define TDA_CB_SEL1     5
`define TDA_CB_START    6
// Trace config fields
`define TDA_CF_MODE     2:0
`define TDA_CF_DET      5:3
`define TDA_CF_AUTO     6
// Readback address fields
`define TDA_RA_PIX      9:0
`define TDA_RA_SRC      11:10
`define TDA_SRC_MEM     2'h2
// Averaging count limits and reset value; auto detector reset value
`define TDA_AVG_MIN     10'h002
`define TDA_AVG_MAX     10'h3E7
`define TDA_AVG_RST     10'h00A
`define TDA_AUTO_RST    1'b1
`endif

//--- src/tda_pkg.sv
`default_nettype none
package tda_pkg;
    typedef enum logic [2:0] {
        TDA_CLRW = 3'h0,
        TDA_AVG  = 3'h1,
        TDA_MAXH = 3'h2,
        TDA_MINH = 3'h3,
        TDA_VIEW = 3'h4
    } tda_mode_t;

    typedef enum logic [2:0] {
        TDA_DUAL = 3'h0,
        TDA_HIGH = 3'h1,
        TDA_LOW  = 3'h2,
        TDA_SAMP = 3'h3,
        TDA_POW  = 3'h4
    } tda_det_t;

    typedef struct packed {
        logic [15:0] level;
        logic        pix_end;
    } tda_sample_t;

    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
        logic [15:0] samp;
        logic [15:0] pow;
    } tda_pixel_t;
endpackage : tda_pkg
`default_nettype wire

//--- src/tda_trace_engine.sv
// Operation
// - Sweep reduced to exactly 711 pixels
// - Detectors work on video voltage samples
// - Overwrite mode replaces every pixel each sweep
// - Average mode: moving average, count 2..999
// - Continuous runs moving; single stops, averages
// - Highest hold keeps largest level per pixel
// - Lowest hold keeps smallest level per pixel
// - Hold restarts on parameter change, start, mode change or trace two enable
// - Highest hold forces highest-value detector
// - Lowest hold forces lowest-value detector
// - View mode freezes trace; measuring stops once all enabled traces view
// - Dual detector gives maximum and minimum
// - Highest detector gives maximum only
// - Lowest detector gives minimum only
// - Sample detector gives one random level
// - Power detector gives mean power per pixel
// - Auto detector follows trace mode table
// - Manual detector ignores later mode changes, except hold modes force it
// - Two traces, own mode/detector; trace one first
// - Enabling trace two activates it; select returns
// - Store copies active trace to static memory
// - Data set save also stores trace
// - Single sweep runs count sweeps in average mode, else one, then stops
`timescale 1ns/10ps
`default_nettype none
`include "tda_params.svh"
module tda_trace_engine
    import tda_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire tda_sample_t smp,
    input  wire logic        smp_valid,
    output logic             smp_ready,
    output logic             meas_run,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack
);
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask
    function automatic tda_det_t pick_det(input tda_mode_t m, input tda_det_t d, input logic a);
        if (!a) return d;
        unique case (m)
            TDA_CLRW: return TDA_DUAL;
            TDA_AVG:  return TDA_SAMP;
            TDA_MAXH: return TDA_HIGH;
            TDA_MINH: return TDA_LOW;
            default:  return d;
        endcase
    endfunction : pick_det
    ////////////////////////////////////////////////////////////////////////////////
    // Register bus
    logic             en2;
    logic             single;
    logic             active;
    logic [9:0]       avg_n;
    logic [11:0]      rd_adr;
    tda_mode_t [1:0]  mode;
    tda_det_t  [1:0]  det_sel;
    logic      [1:0]  auto_det;
    logic      [1:0]  fresh;
    logic [1:0][9:0]  k;
    logic [9:0]       pix_idx;
    logic             store_busy;
    logic [31:0]      rd_word;
    wire        bus_hit  = wb_cyc & wb_stb & ~wb_ack;
    wire        bus_wr   = bus_hit & wb_we;
    wire [31:0] bmask    = lane_mask(wb_sel);
    wire        ctrl_wr  = bus_wr & (wb_adr == `TDA_ADR_CTRL) & wb_sel[0];
    wire        cfg_wr   = bus_wr & (wb_adr == `TDA_ADR_CFG);
    wire        avg_wr   = bus_wr & (wb_adr == `TDA_ADR_AVG);
    wire        rda_wr   = bus_wr & (wb_adr == `TDA_ADR_RDADR);
    wire [31:0] cfg_old  = {25'h0, auto_det[active], det_sel[active], mode[active]};
    wire [31:0] cfg_new  = (cfg_old & ~bmask) | (wb_dat_i & bmask);
    wire [31:0] avg_new  = ({22'h0, avg_n} & ~bmask) | (wb_dat_i & bmask);
    wire [31:0] rda_new  = ({20'h0, rd_adr} & ~bmask) | (wb_dat_i & bmask);
    wire        en2_rise = ctrl_wr & wb_dat_i[`TDA_CB_EN2] & ~en2;
    wire        sel1     = ctrl_wr & wb_dat_i[`TDA_CB_SEL1];
    wire        param_ch = ctrl_wr & wb_dat_i[`TDA_CB_PARAM];
    wire        start    = ctrl_wr & wb_dat_i[`TDA_CB_START];
    wire        store_go = ctrl_wr & (wb_dat_i[`TDA_CB_STORE] | wb_dat_i[`TDA_CB_SAVE]);
    wire [2:0]  wr_mcode = cfg_new[`TDA_CF_MODE];
    wire tda_mode_t wr_mode = (wr_mcode > 3'h4) ? TDA_CLRW : tda_mode_t'(wr_mcode);
    wire [2:0]  wr_dcode = cfg_new[`TDA_CF_DET];
    wire tda_det_t  wr_dsel = (wr_dcode > 3'h4) ? TDA_DUAL : tda_det_t'(wr_dcode);
    wire tda_det_t  wr_det  = (wr_mode == TDA_MAXH) ? TDA_HIGH :
                              (wr_mode == TDA_MINH) ? TDA_LOW : wr_dsel;
    wire [9:0]  avg_raw  = avg_new[9:0];
    wire [9:0]  avg_clmp = (avg_raw < `TDA_AVG_MIN) ? `TDA_AVG_MIN :
                           (avg_raw > `TDA_AVG_MAX) ? `TDA_AVG_MAX : avg_raw;
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_ack   <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack   <= bus_hit;
            wb_dat_o <= (bus_hit & ~wb_we) ? rd_word : 32'h0;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            en2    <= 1'b0;
            single <= 1'b0;
            active <= 1'b0;
            avg_n  <= `TDA_AVG_RST;
            rd_adr <= 12'h0;
        end else begin
            if (ctrl_wr) begin
                en2    <= wb_dat_i[`TDA_CB_EN2];
                single <= wb_dat_i[`TDA_CB_SINGLE];
            end
            if (en2_rise)
                active <= 1'b1;
            else if (sel1 | (ctrl_wr & ~wb_dat_i[`TDA_CB_EN2]))
                active <= 1'b0;
            if (avg_wr)
                avg_n <= avg_clmp;
            if (rda_wr)
                rd_adr <= rda_new[11:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Sweep control
    logic [9:0] sw_cnt;
    logic       single_run;
    wire        acc       = smp_valid & smp_ready;
    wire        sweep_end = acc & smp.pix_end & (pix_idx == `TDA_PIX_LAST);
    wire [9:0]  sw_target = (mode[active] == TDA_AVG) ? avg_n : 10'h001;
    wire        all_view  = (mode[0] == TDA_VIEW) & (~en2 | (mode[1] == TDA_VIEW));
    assign meas_run  = (single ? single_run : 1'b1) & ~all_view;
    assign smp_ready = meas_run;
    always_ff @(posedge clk) begin
        if (reset) begin
            sw_cnt     <= 10'h0;
            single_run <= 1'b0;
        end else if (start) begin
            sw_cnt     <= 10'h0;
            single_run <= 1'b1;
        end else if (sweep_end) begin
            sw_cnt <= sw_cnt + 10'h001;
            if (sw_cnt + 10'h001 >= sw_target)
                single_run <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pixel detectors
    logic [15:0] p_max;
    logic [15:0] p_min;
    logic [15:0] p_samp;
    logic [47:0] p_sq;
    logic [15:0] p_n;
    logic        p_first;
    logic [15:0] lfsr;
    tda_pixel_t  res;
    logic        res_valid;
    logic [9:0]  res_pix;
    wire [15:0] d      = smp.level;
    wire [15:0] c_max  = (p_first | (d > p_max)) ? d : p_max;
    wire [15:0] c_min  = (p_first | (d < p_min)) ? d : p_min;
    wire [15:0] c_samp = (p_first | lfsr[0]) ? d : p_samp;
    wire [31:0] d_sq   = d * d;
    wire [47:0] c_sq   = (p_first ? 48'h0 : p_sq) + {16'h0, d_sq};
    wire [15:0] c_n    = (p_first ? 16'h0 : p_n) + 16'h0001;
    wire [47:0] c_mean = c_sq / {32'h0, c_n};
    wire [15:0] c_pow  = c_mean[31:16];
    always_ff @(posedge clk) begin
        if (reset)
            lfsr <= 16'hACE1;
        else
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            p_first <= 1'b1;
            pix_idx <= 10'h0;
        end else if (acc) begin
            p_first <= smp.pix_end;
            if (smp.pix_end)
                pix_idx <= (pix_idx == `TDA_PIX_LAST) ? 10'h0 : pix_idx + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (acc) begin
            p_max  <= c_max;
            p_min  <= c_min;
            p_samp <= c_samp;
            p_sq   <= c_sq;
            p_n    <= c_n;
        end
        if (acc & smp.pix_end) begin
            res     <= '{hi: c_max, lo: c_min, samp: c_samp, pow: c_pow};
            res_pix <= pix_idx;
        end
    end

    always_ff @(posedge clk) begin
        if (reset)
            res_valid <= 1'b0;
        else
            res_valid <= acc & smp.pix_end;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Trace state
    wire res_done = res_valid & (res_pix == `TDA_PIX_LAST);
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int t = 0; t < 2; t++) begin
                mode[t]     <= TDA_CLRW;
                det_sel[t]  <= TDA_DUAL;
                auto_det[t] <= `TDA_AUTO_RST;
                fresh[t]    <= 1'b1;
                k[t]        <= 10'h0;
            end
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (res_done) begin
                    fresh[t] <= 1'b0;
                    if (k[t] < avg_n)
                        k[t] <= k[t] + 10'h001;
                end
                if (param_ch | start | (en2_rise & (t == 1)) |
                    (cfg_wr & (active == t[0]) & (wr_mode != mode[t]))) begin
                    fresh[t] <= 1'b1;
                    k[t]     <= 10'h0;
                end
                if (cfg_wr & (active == t[0])) begin
                    mode[t]     <= wr_mode;
                    det_sel[t]  <= wr_det;
                    auto_det[t] <= cfg_new[`TDA_CF_AUTO];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trace stores
    logic [9:0]       st_idx;
    logic [1:0][31:0] rd_tr;
    logic [1:0][31:0] st_tr;
    logic [1:0]       tr_we;
    logic [1:0][15:0] tr_old;
    logic [1:0][15:0] tr_new;
    for (genvar t = 0; t < 2; t++) begin : g_tr
        logic [15:0] thi [0:`TDA_PIX_COUNT-1];
        logic [15:0] tlo [0:`TDA_PIX_COUNT-1];
        wire tda_det_t det = pick_det(mode[t], det_sel[t], auto_det[t]);
        wire [15:0] x_hi = (det == TDA_LOW)  ? res.lo :
                           (det == TDA_SAMP) ? res.samp :
                           (det == TDA_POW)  ? res.pow : res.hi;
        wire [15:0] x_lo = (det == TDA_DUAL) ? res.lo : x_hi;
        wire [15:0] o_hi = thi[res_pix];
        wire [15:0] o_lo = tlo[res_pix];
        wire [9:0]  dv   = (k[t] >= avg_n) ? avg_n : k[t] + 10'h001;
        wire signed [17:0] dif = $signed({2'b00, x_hi}) - $signed({2'b00, o_hi});
        wire signed [17:0] q   = dif / $signed({8'h00, dv});
        wire signed [17:0] s   = q + $signed({2'b00, o_hi});
        wire [15:0] n_hi = fresh[t] ? x_hi :
                           (mode[t] == TDA_AVG)  ? s[15:0] :
                           (mode[t] == TDA_MAXH) ? ((x_hi > o_hi) ? x_hi : o_hi) :
                           (mode[t] == TDA_MINH) ? ((x_hi < o_hi) ? x_hi : o_hi) :
                           x_hi;
        wire [15:0] n_lo = fresh[t] ? x_lo :
                           (mode[t] == TDA_AVG)  ? s[15:0] :
                           (mode[t] == TDA_MAXH) ? ((x_lo > o_lo) ? x_lo : o_lo) :
                           (mode[t] == TDA_MINH) ? ((x_lo < o_lo) ? x_lo : o_lo) :
                           x_lo;
        wire we = res_valid & ((t == 0) | en2) & (mode[t] != TDA_VIEW);
        assign tr_we[t]  = we;
        assign tr_old[t] = o_hi;
        assign tr_new[t] = n_hi;
        assign rd_tr[t]  = {tlo[rd_adr[`TDA_RA_PIX]], thi[rd_adr[`TDA_RA_PIX]]};
        assign st_tr[t]  = {tlo[st_idx], thi[st_idx]};

        always_ff @(posedge clk) begin
            if (we) begin
                thi[res_pix] <= n_hi;
                tlo[res_pix] <= n_lo;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Static memory trace
    logic [31:0] mem_tr [0:`TDA_PIX_COUNT-1];
    always_ff @(posedge clk) begin
        if (reset) begin
            store_busy <= 1'b0;
            st_idx     <= 10'h0;
        end else if (store_busy) begin
            st_idx     <= st_idx + 10'h001;
            store_busy <= (st_idx != `TDA_PIX_LAST);
        end else if (store_go) begin
            store_busy <= 1'b1;
            st_idx     <= 10'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (store_busy)
            mem_tr[st_idx] <= st_tr[active];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux
    wire [31:0] stat_word = {8'h0, store_busy, meas_run, single, active, k[active],
                             pix_idx};
    wire [31:0] data_word = (rd_adr[`TDA_RA_SRC] == `TDA_SRC_MEM) ?
                            mem_tr[rd_adr[`TDA_RA_PIX]] : rd_tr[rd_adr[10]];
    always_comb begin
        unique case (wb_adr)
            `TDA_ADR_CTRL:  rd_word = {30'h0, single, en2};
            `TDA_ADR_CFG:   rd_word = cfg_old;
            `TDA_ADR_AVG:   rd_word = {22'h0, avg_n};
            `TDA_ADR_STAT:  rd_word = stat_word;
            `TDA_ADR_RDADR: rd_word = {20'h0, rd_adr};
            `TDA_ADR_RDDAT: rd_word = data_word;
            default:        rd_word = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_pixel_wrap: assert property (sweep_end |=> pix_idx == 10'h0)
        else $error("pixel index did not wrap after last pixel");
    a_pixel_range: assert property (pix_idx <= `TDA_PIX_LAST)
        else $error("pixel index beyond row");
    a_view_frozen: assert property (mode[0] == TDA_VIEW |-> !tr_we[0])
        else $error("frozen trace written");
    a_max_force: assert property (cfg_wr && wr_mode == TDA_MAXH |=> det_sel[active] == TDA_HIGH)
        else $error("highest hold did not force detector");
    a_min_force: assert property (cfg_wr && wr_mode == TDA_MINH |=> det_sel[active] == TDA_LOW)
        else $error("lowest hold did not force detector");
    a_hold_max: assert property (tr_we[0] && mode[0] == TDA_MAXH && !fresh[0]
                                 |-> tr_new[0] >= tr_old[0])
        else $error("highest hold decreased");
    a_hold_min: assert property (tr_we[0] && mode[0] == TDA_MINH && !fresh[0]
                                 |-> tr_new[0] <= tr_old[0])
        else $error("lowest hold increased");
    a_dual_order: assert property (res_valid |-> res.hi >= res.lo)
        else $error("pixel maximum below minimum");
    a_single_stop: assert property (single && sweep_end && !start
                                    && sw_cnt + 10'h001 >= sw_target |=> !meas_run)
        else $error("single sweep did not stop");
    a_trace2_act: assert property (en2_rise |=> active)
        else $error("second trace not active after enable");
    a_store_len: assert property ($rose(store_busy) |-> store_busy [*8])
        else $error("store ended early");
    a_clear_mode: assert property (cfg_wr && wr_mode != mode[active] |=> fresh[active])
        else $error("mode change did not clear accumulators");
    c_sweep_done: cover property (sweep_end);
    c_avg_full: cover property (mode[0] == TDA_AVG && k[0] == avg_n);
    c_store_run: cover property (store_busy && st_idx == `TDA_PIX_LAST);
    c_two_traces: cover property (en2 && tr_we[1]);
endmodule : tda_trace_engine
`default_nettype wire

//--- verif/tda_sweep_src.sv
`timescale 1ns/10ps
`default_nettype none
`include "tda_params.svh"
module tda_sweep_src
    import tda_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] base_a,
    input  wire logic [15:0] base_b,
    input  wire logic        smp_ready,
    output tda_sample_t      smp,
    output logic             smp_valid,
    output logic             busy
);
    int p;
    int k;
    initial begin
        smp = '0;
        smp_valid = 1'b0;
        busy = 1'b0;
    end
    // Two samples a pixel, held until taken
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (p = 0; p < `TDA_PIX_COUNT; p++) begin
                for (k = 0; k < 2; k++) begin
                    smp.level   <= (k == 0 ? base_a : base_b) + 16'(p);
                    smp.pix_end <= (k == 1);
                    smp_valid   <= 1'b1;
                    @(posedge clk);
                    while (smp_ready !== 1'b1) @(posedge clk);
                end
            end
            smp_valid <= 1'b0;
            // Released line must not keep the last level
            smp.level <= ~smp.level;
            busy      <= 1'b0;
        end
    end
endmodule : tda_sweep_src
`default_nettype wire

//--- verif/tb_trace_detector_and_averager.sv
`timescale 1ns/10ps
`default_nettype none
`include "tda_params.svh"
module tb_trace_detector_and_averager;
    import tda_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    tda_sample_t smp;
    logic        smp_valid;
    logic        smp_ready;
    logic        meas_run;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack;
    logic        go = 1'b0;
    logic [15:0] base_a = 16'h0;
    logic [15:0] base_b = 16'h0;
    logic        busy;
    int          errors = 0;
    int          tests_run = 0;

    always #2 clk = ~clk;

    tda_trace_engine DUT (.clk(clk), .reset(reset), .smp(smp), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .meas_run(meas_run), .wb_cyc(cyc), .wb_stb(stb),
        .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
        .wb_ack(ack));
    tda_sweep_src src (.clk(clk), .go(go), .base_a(base_a), .base_b(base_b),
        .smp_ready(smp_ready), .smp(smp), .smp_valid(smp_valid), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic cycle, held until ack, one idle cycle after
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            errors++;
            $display("mismatch at %0t: bus timeout", $time);
        end
    endtask : wb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr

    task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(q & m, e);
    endtask : rc

    task pix(input logic [1:0] s, input logic [9:0] p, input logic [31:0] m,
             input logic [31:0] e);
        wr(`TDA_ADR_RDADR, {20'h0, s, p});
        rc(`TDA_ADR_RDDAT, m, e);
    endtask : pix

    task sweep(input logic [15:0] a, input logic [15:0] b);
        int n;
        n = 0;
        base_a <= a;
        base_b <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        chk(n < 5000, 32'h1);
    endtask : sweep

    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rc(`TDA_ADR_CTRL, 32'hFFFFFFFF, 32'h0);
        rc(`TDA_ADR_CFG, 32'h7F, 32'h40);
        rc(`TDA_ADR_AVG, 32'h3FF, 32'h00A);
        rc(`TDA_ADR_STAT, 32'h00700000, 32'h00400000);
        rc(8'h20, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, meas_run}, 32'h1);
    endtask : t_reset

    task t_clrw;
        sweep(16'h0064, 16'h0032);
        pix(2'h0, 10'h000, 32'hFFFFFFFF, 32'h00320064);
        pix(2'h0, 10'h2C6, 32'hFFFFFFFF, 32'h02F8032A);
        rc(`TDA_ADR_STAT, 32'h3FF, 32'h0);
        sweep(16'h005A, 16'h0028);
        pix(2'h0, 10'h000, 32'hFFFFFFFF, 32'h0028005A);
    endtask : t_clrw

    task t_hold;
        wr(`TDA_ADR_CFG, 32'h42);
        rc(`TDA_ADR_CFG, 32'h7F, 32'h4A);
        sweep(16'h012C, 16'h000A);
        sweep(16'h00C8, 16'h000A);
        pix(2'h0, 10'h005, 32'hFFFF, 32'h0131);
        wr(`TDA_ADR_CTRL, 32'h04);
        sweep(16'h00C8, 16'h000A);
        pix(2'h0, 10'h005, 32'hFFFF, 32'h00CD);
        wr(`TDA_ADR_CFG, 32'h43);
        rc(`TDA_ADR_CFG, 32'h7F, 32'h53);
        sweep(16'h01F4, 16'h0190);
        sweep(16'h0258, 16'h01C2);
        pix(2'h0, 10'h007, 32'hFFFF0000, 32'h01970000);
    endtask : t_hold

    task t_avg;
        logic [31:0] q;
        logic        ok;
        wr(`TDA_ADR_CFG, 32'h20);
        sweep(16'h1000, 16'h1000);
        pix(2'h0, 10'h000, 32'hFFFFFFFF, 32'h01000100);
        wr(`TDA_ADR_CFG, 32'h21);
        rc(`TDA_ADR_CFG, 32'h7F, 32'h21);
        wr(`TDA_ADR_CFG, 32'h41);
        rc(`TDA_ADR_CFG, 32'h7F, 32'h41);
        wr(`TDA_ADR_AVG, 32'h1);
        rc(`TDA_ADR_AVG, 32'h3FF, 32'h2);
        wr(`TDA_ADR_AVG, 32'h3E8);
        rc(`TDA_ADR_AVG, 32'h3FF, 32'h3E7);
        wr(`TDA_ADR_AVG, 32'h4);
        // Auto detector in average picks one sample: both halves equal, one of the two levels
        sweep(16'h0300, 16'h0200);
        wr(`TDA_ADR_RDADR, 32'h003);
        wb(`TDA_ADR_RDDAT, 1'b0, 32'h0, q);
        ok = (q[31:16] == q[15:0]) && (q[15:0] == 16'h0303 || q[15:0] == 16'h0203);
        chk({31'h0, ok}, 32'h1);
        wr(`TDA_ADR_CTRL, 32'h04);
        sweep(16'h03E8, 16'h03E8);
        pix(2'h0, 10'h003, 32'hFFFFFFFF, 32'h03EB03EB);
        sweep(16'h07D0, 16'h07D0);
        pix(2'h0, 10'h003, 32'hFFFFFFFF, 32'h05DF05DF);
    endtask : t_avg

    task t_trace2;
        wr(`TDA_ADR_CTRL, 32'h01);
        rc(`TDA_ADR_STAT, 32'h00100000, 32'h00100000);
        rc(`TDA_ADR_CFG, 32'h7F, 32'h40);
        wr(`TDA_ADR_CFG, 32'h43);
        sweep(16'h02BC, 16'h02BC);
        pix(2'h1, 10'h001, 32'hFFFF0000, 32'h02BD0000);
        wr(`TDA_ADR_CTRL, 32'h09);
        repeat (720) @(posedge clk);
        rc(`TDA_ADR_STAT, 32'h00800000, 32'h0);
        pix(2'h2, 10'h009, 32'hFFFF0000, 32'h02C50000);
        sweep(16'h0064, 16'h0064);
        pix(2'h2, 10'h009, 32'hFFFF0000, 32'h02C50000);
        wr(`TDA_ADR_CTRL, 32'h11);
        repeat (720) @(posedge clk);
        pix(2'h2, 10'h009, 32'hFFFF0000, 32'h006D0000);
        wr(`TDA_ADR_CTRL, 32'h21);
        rc(`TDA_ADR_STAT, 32'h00100000, 32'h0);
        rc(`TDA_ADR_CFG, 32'h7F, 32'h41);
    endtask : t_trace2

    task t_single_view;
        wr(`TDA_ADR_CFG, 32'h40);
        wr(`TDA_ADR_CTRL, 32'h02);
        chk({31'h0, meas_run}, 32'h0);
        wr(`TDA_ADR_CTRL, 32'h42);
        chk({31'h0, smp_ready}, 32'h1);
        sweep(16'h0010, 16'h0008);
        chk({31'h0, meas_run}, 32'h0);
        pix(2'h0, 10'h000, 32'hFFFFFFFF, 32'h00080010);
        wr(`TDA_ADR_CTRL, 32'h00);
        chk({31'h0, meas_run}, 32'h1);
        wr(`TDA_ADR_CFG, 32'h44);
        chk({30'h0, meas_run, smp_ready}, 32'h0);
        rc(`TDA_ADR_STAT, 32'h00400000, 32'h0);
        pix(2'h0, 10'h000, 32'hFFFFFFFF, 32'h00080010);
    endtask : t_single_view

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_clrw();
        t_hold();
        t_avg();
        t_trace2();
        t_single_view();
        end_of_test();
    end
endmodule : tb_trace_detector_and_averager
`default_nettype wire
